// file: logic/ccu_pkg.sv
// constants and types shared by the capture and compare unit
`default_nettype none
package ccu_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CONTROL   = 5'h00;
  localparam logic [4:0] OFF_VALUE     = 5'h04;
  localparam logic [4:0] OFF_TIMEBASE  = 5'h08;
  localparam logic [4:0] OFF_TIMER_CTL = 5'h0c;
  localparam logic [4:0] OFF_STATUS    = 5'h10;
  localparam logic [4:0] OFF_MASK      = 5'h14;
  localparam logic [4:0] OFF_PORT_DIR  = 5'h18;
  localparam logic [4:0] OFF_PORT_DATA = 5'h1c;

  // ----------------------------------------------------------------
  // mode select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFF       = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
  localparam logic [3:0] MODE_CAP_4TH   = 4'h6;
  localparam logic [3:0] MODE_CAP_16TH  = 4'h7;
  localparam logic [3:0] MODE_CMP_HIGH  = 4'h8;
  localparam logic [3:0] MODE_CMP_LOW   = 4'h9;
  localparam logic [3:0] MODE_CMP_KEEP  = 4'ha;
  localparam logic [3:0] MODE_CMP_KEEP2 = 4'hb;

  // prescaler terminal counts (edges minus one)
  localparam logic [3:0] PRESC_LAST_4   = 4'h3;
  localparam logic [3:0] PRESC_LAST_16  = 4'hf;

  // ----------------------------------------------------------------
  // timebase sources and field positions
  // ----------------------------------------------------------------
  localparam logic [1:0] TSRC_INTERNAL  = 2'h0;
  localparam logic [1:0] TSRC_EXT_SYNC  = 2'h1;
  localparam logic [1:0] TSRC_EXT_ASYNC = 2'h2;

  localparam int STAT_UNIT_BIT = 0;
  localparam int STAT_OVF_BIT  = 1;
  localparam int PIN_BIT       = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  CONTROL_RESET   = 4'h0;
  localparam logic [15:0] VALUE_RESET     = 16'h0000;
  localparam logic [15:0] TIMEBASE_RESET  = 16'h0000;
  localparam logic [7:0]  PORT_DIR_RESET  = 8'hff;
  localparam logic [7:0]  PORT_DATA_RESET = 8'h00;
  localparam logic [1:0]  STATUS_RESET    = 2'h0;
  localparam logic [1:0]  MASK_RESET      = 2'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rise;
    logic fall;
  } edge_pulses_t;

  typedef struct packed {
    logic [1:0] src;
    logic       run;
  } timer_ctl_t;

endpackage
`default_nettype wire

// file: logic/pin_edge_detect.sv
// two-stage pin synchroniser with rise and fall pulse outputs
`default_nettype none
`timescale 1ns/1ps
module pin_edge_detect
  import ccu_pkg::*;
(
  input  wire logic    sys_clk,
  input  wire logic    resetn,
  input  wire logic    pin_async,
  output edge_pulses_t edges,
  output logic         level
);

  logic sync1_reg;
  logic sync2_reg;

  // ----------------------------------------------------------------
  // synchroniser and edge pulses
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_async;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      level <= 1'b0;
      edges <= '0;
    end else begin
      level      <= sync2_reg;
      edges.rise <= sync2_reg & ~level;
      edges.fall <= ~sync2_reg & level;
    end
  end

  one_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    edges.rise |-> level && !$past(level)) else $error("rise pulse without new high level");

endmodule // pin_edge_detect
`default_nettype wire

// file: logic/capture_compare_unit.sv
// capture and compare unit around a 16-bit timebase, Avalon-MM slave
//
// Notes on behaviour
// - capture suppressed while timebase counts asynchronously
// - capture mode change may set flag
// - two capture prescaler settings from mode field
// - prescaler cleared when off or not capturing
// - capture to capture switch keeps prescaler count
// - compare value checked against timebase every cycle
// - match drives pin high, low, or unchanged
// - match sets flag with pin action
// - control write of zero clears compare latch
// - falling, rising, fourth or sixteenth rising edge
// - capture copies full timebase into value register
// - capture sets sticky flag, overwrites older value
`default_nettype none
`timescale 1ns/1ps
module capture_compare_unit
  import ccu_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        event_pin_in,
  output logic             event_pin_out,
  output logic             event_pin_oe_n,
  input  wire logic        ext_clk_pin,
  output logic             irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [3:0]   mode_select_field;
  logic [15:0]  capture_compare_value;
  logic [15:0]  timebase_counter;
  timer_ctl_t   timer_ctl_reg;
  logic [1:0]   status_reg;
  logic [1:0]   mask_reg;
  logic [7:0]   port_direction_reg;
  logic [7:0]   port_data_reg;
  logic [3:0]   presc_cnt_reg;
  logic         cmp_latch_reg;
  logic         ack_reg;
  edge_pulses_t pin_edges;
  edge_pulses_t ext_edges;
  logic         pin_level;
  logic         wr_go;
  logic         ctl_wr;
  logic [3:0]   mode_next;
  logic         cap_mode;
  logic         cmp_mode;
  logic         cap_allowed;
  logic         cap_edge;
  logic         cap_event;
  logic         presc_mode;
  logic [3:0]   presc_last;
  logic         mode_glitch;
  logic         cmp_match;
  logic         tick;
  logic         overflow;
  logic [31:0]  wmask;
  logic [31:0]  rd_next;

  // ----------------------------------------------------------------
  // pin and external clock synchronisers
  // ----------------------------------------------------------------
  pin_edge_detect u_pin_sync (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .pin_async (event_pin_in),
    .edges     (pin_edges),
    .level     (pin_level)
  );

  pin_edge_detect u_ext_sync (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .pin_async (ext_clk_pin),
    .edges     (ext_edges),
    .level     ()
  );

  // ----------------------------------------------------------------
  // bus slave: one wait state per access
  // ----------------------------------------------------------------
  assign waitrequest = (read | write) & ~ack_reg;
  assign wr_go       = write & ack_reg;
  assign ctl_wr      = wr_go && (address == OFF_CONTROL) && byteenable[0];
  assign mode_next   = writedata[3:0];

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{byteenable[i]}};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    case (address)
      OFF_CONTROL:   rd_next[3:0]  = mode_select_field;
      OFF_VALUE:     rd_next[15:0] = capture_compare_value;
      OFF_TIMEBASE:  rd_next[15:0] = timebase_counter;
      OFF_TIMER_CTL: rd_next[2:0]  = timer_ctl_reg;
      OFF_STATUS:    rd_next[1:0]  = status_reg;
      OFF_MASK:      rd_next[1:0]  = mask_reg;
      OFF_PORT_DIR:  rd_next[7:0]  = port_direction_reg;
      OFF_PORT_DATA: rd_next[7:0]  = port_data_reg;
      default:       rd_next       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_reg) begin
      readdata <= rd_next & wmask;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mode_select_field <= CONTROL_RESET;
    end else if (ctl_wr) begin
      mode_select_field <= mode_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      timer_ctl_reg      <= '0;
      mask_reg           <= MASK_RESET;
      port_direction_reg <= PORT_DIR_RESET;
      port_data_reg      <= PORT_DATA_RESET;
    end else if (wr_go && byteenable[0]) begin
      case (address)
        OFF_TIMER_CTL: timer_ctl_reg      <= writedata[2:0];
        OFF_MASK:      mask_reg           <= writedata[1:0];
        OFF_PORT_DIR:  port_direction_reg <= writedata[7:0];
        OFF_PORT_DATA: port_data_reg      <= writedata[7:0];
        default:       mask_reg           <= mask_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // timebase counter
  // ----------------------------------------------------------------
  always_comb begin
    case (timer_ctl_reg.src)
      TSRC_INTERNAL: tick = timer_ctl_reg.run;
      TSRC_EXT_SYNC: tick = timer_ctl_reg.run & ext_edges.rise;
      default:       tick = timer_ctl_reg.run & ext_edges.rise;
    endcase
  end

  assign overflow = tick && (timebase_counter == 16'hffff);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      timebase_counter <= TIMEBASE_RESET;
    end else if (wr_go && address == OFF_TIMEBASE) begin
      timebase_counter <= (timebase_counter & ~wmask[15:0]) | (writedata[15:0] & wmask[15:0]);
    end else if (tick) begin
      timebase_counter <= timebase_counter + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  assign cap_mode    = (mode_select_field >= MODE_CAP_FALL) &&
                       (mode_select_field <= MODE_CAP_16TH);
  assign cmp_mode    = (mode_select_field >= MODE_CMP_HIGH) &&
                       (mode_select_field <= MODE_CMP_KEEP2);
  assign cap_allowed = cap_mode && (timer_ctl_reg.src != TSRC_EXT_ASYNC);
  assign presc_mode  = (mode_select_field == MODE_CAP_4TH) ||
                       (mode_select_field == MODE_CAP_16TH);
  assign presc_last  = (mode_select_field == MODE_CAP_16TH) ? PRESC_LAST_16
                                                            : PRESC_LAST_4;

  // direct switch between two different capture settings glitches the flag
  assign mode_glitch = ctl_wr && cap_mode && (mode_next != mode_select_field) &&
                       (mode_next >= MODE_CAP_FALL) && (mode_next <= MODE_CAP_16TH);

  // ----------------------------------------------------------------
  // capture edge select and prescaler
  // ----------------------------------------------------------------
  always_comb begin
    case (mode_select_field)
      MODE_CAP_FALL: cap_edge = pin_edges.fall;
      MODE_CAP_RISE: cap_edge = pin_edges.rise;
      MODE_CAP_4TH:  cap_edge = pin_edges.rise && (presc_cnt_reg >= presc_last);
      MODE_CAP_16TH: cap_edge = pin_edges.rise && (presc_cnt_reg >= presc_last);
      default:       cap_edge = 1'b0;
    endcase
  end

  assign cap_event = cap_allowed && cap_edge;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      presc_cnt_reg <= 4'h0;
    end else if (!cap_mode) begin
      presc_cnt_reg <= 4'h0;
    end else if (presc_mode && cap_allowed && pin_edges.rise) begin
      // a count left over from another setting is kept, not cleared
      presc_cnt_reg <= (presc_cnt_reg >= presc_last) ? 4'h0 : presc_cnt_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // capture and compare value
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      capture_compare_value <= VALUE_RESET;
    end else if (cap_event) begin
      capture_compare_value <= timebase_counter;
    end else if (wr_go && address == OFF_VALUE) begin
      capture_compare_value <= (capture_compare_value & ~wmask[15:0]) |
                               (writedata[15:0] & wmask[15:0]);
    end
  end

  // ----------------------------------------------------------------
  // compare match and output latch
  // ----------------------------------------------------------------
  assign cmp_match = cmp_mode && (timebase_counter == capture_compare_value);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cmp_latch_reg <= 1'b0;
    end else if (ctl_wr && mode_next == MODE_OFF) begin
      cmp_latch_reg <= 1'b0;
    end else if (cmp_match && mode_select_field == MODE_CMP_HIGH) begin
      cmp_latch_reg <= 1'b1;
    end else if (cmp_match && mode_select_field == MODE_CMP_LOW) begin
      cmp_latch_reg <= 1'b0;
    end
  end

  // compare mode steers the pin from the compare latch, else the port latch
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      event_pin_out  <= 1'b0;
      event_pin_oe_n <= 1'b1;
    end else begin
      event_pin_out  <= cmp_mode ? cmp_latch_reg : port_data_reg[PIN_BIT];
      event_pin_oe_n <= port_direction_reg[PIN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // sticky status, mask and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      status_reg <= STATUS_RESET;
    end else begin
      // set wins over a write-one clear in the same cycle
      if (cap_event || cmp_match || mode_glitch) begin
        status_reg[STAT_UNIT_BIT] <= 1'b1;
      end else if (wr_go && address == OFF_STATUS && byteenable[0] &&
                   writedata[STAT_UNIT_BIT]) begin
        status_reg[STAT_UNIT_BIT] <= 1'b0;
      end
      if (overflow) begin
        status_reg[STAT_OVF_BIT] <= 1'b1;
      end else if (wr_go && address == OFF_STATUS && byteenable[0] &&
                   writedata[STAT_OVF_BIT]) begin
        status_reg[STAT_OVF_BIT] <= 1'b0;
      end
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  async_no_cap_a: assert property (
    timer_ctl_reg.src == TSRC_EXT_ASYNC |-> !cap_event)
    else $error("capture while timebase is asynchronous");

  glitch_flag_a: assert property (
    mode_glitch |=> status_reg[STAT_UNIT_BIT])
    else $error("capture setting change did not set flag");

  presc_clear_a: assert property (
    !cap_mode |=> presc_cnt_reg == 4'h0)
    else $error("prescaler not cleared outside capture");

  presc_keep_a: assert property (
    mode_glitch && !pin_edges.rise |=> presc_cnt_reg == $past(presc_cnt_reg))
    else $error("prescaler lost on direct setting change");

  sixteenth_edge_a: assert property (
    cap_event && mode_select_field == MODE_CAP_16TH |->
      pin_edges.rise && presc_cnt_reg == PRESC_LAST_16 ##1 presc_cnt_reg == 4'h0)
    else $error("sixteenth edge capture out of step");

  fall_edge_a: assert property (
    cap_event && mode_select_field == MODE_CAP_FALL |-> pin_edges.fall && !pin_level)
    else $error("falling capture without falling edge");

  cap_store_a: assert property (
    cap_event |=> capture_compare_value == $past(timebase_counter) &&
                  status_reg[STAT_UNIT_BIT])
    else $error("capture did not store timebase and flag");

  match_drive_a: assert property (
    cmp_match && mode_select_field == MODE_CMP_HIGH && !ctl_wr |=>
      cmp_latch_reg && status_reg[STAT_UNIT_BIT] ##1 (event_pin_out || !$past(cmp_mode)))
    else $error("compare match did not drive pin high with flag");

  match_low_a: assert property (
    cmp_match && mode_select_field == MODE_CMP_LOW |=> !cmp_latch_reg)
    else $error("compare match did not drive latch low");

  keep_pin_a: assert property (
    cmp_match && mode_select_field == MODE_CMP_KEEP && !ctl_wr |=>
      $stable(cmp_latch_reg) && status_reg[STAT_UNIT_BIT])
    else $error("keep mode changed compare latch");

  cont_match_a: assert property (
    cmp_mode && timebase_counter == capture_compare_value |=> status_reg[STAT_UNIT_BIT])
    else $error("equal compare value missed");

  off_clear_a: assert property (
    ctl_wr && mode_next == MODE_OFF |=> !cmp_latch_reg &&
      port_data_reg == $past(port_data_reg))
    else $error("control clear left compare latch high");

endmodule // capture_compare_unit
`default_nettype wire

// file: sim/pin_model.sv
// external pin source and load beside the capture and compare unit
`default_nettype none
`timescale 1ns/1ps
module pin_model (
  input  wire logic sys_clk,
  input  wire logic event_pin_out,
  input  wire logic event_pin_oe_n,
  output logic      pin_level,
  output logic      ext_clk
);
  logic       src_level   = 1'b0;
  logic       ext_clk_reg = 1'b0;
  logic [2:0] div         = 3'h0;

  assign ext_clk = ext_clk_reg;

  // the unit owns the wire while its enable is low
  assign pin_level = event_pin_oe_n ? src_level : event_pin_out;

  // slow free-running external timebase clock
  always @(posedge sys_clk) begin
    div <= div + 3'h1;
    if (div == 3'h6) begin
      ext_clk_reg <= ~ext_clk_reg;
    end
  end

  // level held long enough to pass the two synchroniser stages
  task automatic set(input logic v);
    src_level <= v;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule // pin_model
`default_nettype wire

// file: sim/test_capture_compare_unit.sv
// self-checking bench for the capture and compare unit
`default_nettype none
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module test_capture_compare_unit;
  import ccu_pkg::*;
  logic        sys_clk;
  logic        resetn;
  logic        read;
  logic        write;
  logic        waitrequest;
  logic        event_pin_out;
  logic        event_pin_oe_n;
  logic        irq;
  logic        pin_level;
  logic        ext_clk;
  logic [4:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic [31:0] rd_val;
  int          n_mismatch = 0;
  int          checks_done = 0;

  always #2.5 sys_clk = ~sys_clk;

  capture_compare_unit i_capture_compare_unit (
    .sys_clk(sys_clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .event_pin_in(pin_level),
    .event_pin_out(event_pin_out), .event_pin_oe_n(event_pin_oe_n),
    .ext_clk_pin(ext_clk), .irq(irq));

  pin_model i_pin_model (
    .sys_clk(sys_clk), .event_pin_out(event_pin_out),
    .event_pin_oe_n(event_pin_oe_n), .pin_level(pin_level), .ext_clk(ext_clk));

  // ----------------------------------------------------------------
  // bus and helper tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd,
                     input logic [3:0] be);
    int n;
    n = 0;
    address <= a;
    writedata <= wd;
    byteenable <= be;
    write <= w;
    read <= ~w;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        n_mismatch++;
        finish_test();
      end
      @(posedge sys_clk);
    end
    // taken at this edge; registered outputs settle one edge later
    rd_val = readdata;
    read <= 1'b0;
    write <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    `CHK(rd_val, e)
  endtask

  task automatic mode(input logic [3:0] m);
    wr(OFF_CONTROL, {28'h0, m});
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      i_pin_model.set(1'b1);
      i_pin_model.set(1'b0);
    end
  endtask

  // polls the flag while the timebase runs from zero towards the compare value
  task automatic wait_flag();
    int n;
    n = 0;
    wr(OFF_TIMEBASE, 32'h0);
    wr(OFF_STATUS, 32'h1);
    rd_val = 32'h0;
    while (rd_val[0] !== 1'b1) begin
      n++;
      if (n > 100) begin
        n_mismatch++;
        finish_test();
      end
      bus(1'b0, OFF_STATUS, 32'h0, 4'hf);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk(OFF_CONTROL, 32'h0);
    rdchk(OFF_PORT_DIR, 32'hff);
    rdchk(OFF_STATUS, 32'h0);
    `CHK(event_pin_oe_n, 1'b1)
    `CHK(irq, 1'b0)
    bus(1'b1, OFF_TIMEBASE, 32'h0000_abcd, 4'h1);
    rdchk(OFF_TIMEBASE, 32'h0000_00cd);
  endtask

  task automatic t_capture();
    wr(OFF_TIMEBASE, 32'h0000_1234);
    mode(MODE_CAP_RISE);
    wr(OFF_STATUS, 32'h1);
    wr(OFF_MASK, 32'h1);
    pulse(1);
    rdchk(OFF_VALUE, 32'h0000_1234);
    rdchk(OFF_STATUS, 32'h1);
    `CHK(irq, 1'b1)
    wr(OFF_TIMEBASE, 32'h0000_4321);
    pulse(1);
    rdchk(OFF_VALUE, 32'h0000_4321);
    wr(OFF_MASK, 32'h0);
    `CHK(irq, 1'b0)
    wr(OFF_STATUS, 32'h1);
    rdchk(OFF_STATUS, 32'h0);
    mode(MODE_OFF);
    mode(MODE_CAP_FALL);
    wr(OFF_TIMEBASE, 32'h0000_0aaa);
    i_pin_model.set(1'b1);
    rdchk(OFF_STATUS, 32'h0);
    wr(OFF_TIMEBASE, 32'h0000_0bbb);
    i_pin_model.set(1'b0);
    rdchk(OFF_VALUE, 32'h0000_0bbb);
    rdchk(OFF_STATUS, 32'h1);
  endtask

  task automatic t_prescale();
    for (int i = 0; i < 2; i++) begin
      mode(MODE_OFF);
      mode(i == 0 ? MODE_CAP_4TH : MODE_CAP_16TH);
      wr(OFF_STATUS, 32'h1);
      pulse(i == 0 ? 3 : 15);
      rdchk(OFF_STATUS, 32'h0);
      pulse(1);
      rdchk(OFF_STATUS, 32'h1);
    end
  endtask

  task automatic t_switch();
    wr(OFF_MASK, 32'h0);
    mode(MODE_OFF);
    mode(MODE_CAP_4TH);
    wr(OFF_STATUS, 32'h1);
    pulse(2);
    mode(MODE_CAP_16TH);
    rdchk(OFF_STATUS, 32'h1);
    wr(OFF_STATUS, 32'h1);
    pulse(13);
    rdchk(OFF_STATUS, 32'h0);
    pulse(1);
    rdchk(OFF_STATUS, 32'h1);
    wr(OFF_STATUS, 32'h1);
    mode(MODE_OFF);
    mode(MODE_CAP_16TH);
    rdchk(OFF_STATUS, 32'h0);
    pulse(15);
    rdchk(OFF_STATUS, 32'h0);
    pulse(1);
    rdchk(OFF_STATUS, 32'h1);
  endtask

  task automatic t_async();
    mode(MODE_OFF);
    wr(OFF_TIMER_CTL, 32'h4);
    mode(MODE_CAP_RISE);
    wr(OFF_VALUE, 32'h0000_5555);
    wr(OFF_STATUS, 32'h1);
    pulse(1);
    rdchk(OFF_STATUS, 32'h0);
    rdchk(OFF_VALUE, 32'h0000_5555);
    wr(OFF_TIMER_CTL, 32'h2);
    wr(OFF_TIMEBASE, 32'h0000_0777);
    pulse(1);
    rdchk(OFF_VALUE, 32'h0000_0777);
    wr(OFF_TIMER_CTL, 32'h0);
  endtask

  task automatic t_compare();
    mode(MODE_OFF);
    wr(OFF_PORT_DATA, 32'h9);
    wr(OFF_PORT_DIR, 32'hf7);
    `CHK(event_pin_oe_n, 1'b0)
    wr(OFF_VALUE, 32'h0000_0080);
    wr(OFF_TIMEBASE, 32'h0);
    mode(MODE_CMP_HIGH);
    wr(OFF_TIMER_CTL, 32'h1);
    `CHK(event_pin_out, 1'b0)
    wait_flag();
    `CHK(event_pin_out, 1'b1)
    mode(MODE_CMP_KEEP);
    wait_flag();
    `CHK(event_pin_out, 1'b1)
    mode(MODE_CMP_LOW);
    wait_flag();
    `CHK(event_pin_out, 1'b0)
    mode(MODE_CMP_HIGH);
    wait_flag();
    `CHK(event_pin_out, 1'b1)
    mode(MODE_CMP_KEEP2);
    wait_flag();
    `CHK(event_pin_out, 1'b1)
    mode(MODE_OFF);
    `CHK(event_pin_out, 1'b1)
    mode(MODE_CMP_KEEP);
    `CHK(event_pin_out, 1'b0)
    mode(MODE_OFF);
    rdchk(OFF_PORT_DATA, 32'h9);
    wr(OFF_MASK, 32'h2);
    wr(OFF_STATUS, 32'h3);
    wr(OFF_TIMEBASE, 32'h0000_fffe);
    repeat (4) @(posedge sys_clk);
    rdchk(OFF_STATUS, 32'h2);
    `CHK(irq, 1'b1)
    wr(OFF_STATUS, 32'h2);
    `CHK(irq, 1'b0)
    wr(OFF_TIMER_CTL, 32'h0);
  endtask

  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h0;
    writedata = 32'h0;
    byteenable = 4'h0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_capture();
    t_prescale();
    t_switch();
    t_async();
    t_compare();
    finish_test();
  end
endmodule // test_capture_compare_unit
`default_nettype wire
